// *** rtl/scp_clock_power_ctrl.sv ***
// Core clock selection and operating mode sequencer.
//
// Summary of operation
// - Core clock from fast or sub clock.
// - Fast source chosen by fixed configuration.
// - Sub source chosen by fixed configuration.
// - Fast clock divisible by two through 64.
// - Sub clock substitutes right after wake-up.
// - Sub clock feeds watchdog, time base, timers.
// - Switching to sub clock stops fast oscillator.
// - Seven modes: three run, four halt CPU.
// - Normal: fast divided 1..64, sub running.
// - Slow: CPU on sub clock, fast off.
// - Halt, idle bit low: sleep, core off.
// - Deep sleep stops sub and watchdog clocks.
// - Retaining sleep keeps sub for watchdog.
// - Sleep forces voltage detect off.
// - Halt, idle, keep low: clock-off idle.
// - Clock-off idle: watchdog clock follows source.
// - Core-sourced watchdog clock off when core stops.
// - Halt, idle, keep high: clock-on idle.
// - Clock-on idle keeps oscillator and watchdog.
// - Divider codes: sub, then /64 down to /2.
// - High select bit picks undivided fast clock.
// - Fast wake: sub until 128 crystal cycles.
`timescale 1ns/100ps

module scp_clock_power_ctrl (
  // Clock and reset.
  input  wire logic              ref_clk,
  input  wire logic              srst,
  // Register port.
  input  wire logic [3:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // CPU events.
  input  wire logic              halt_exec,
  input  wire logic              wake_event,
  // Configuration options and neighbour enables.
  input  wire logic              fast_src_is_rc,
  input  wire logic              sub_src_is_rc,
  input  wire logic              wdt_src_sub,
  input  wire logic              wdt_enable,
  input  wire logic              voltage_detect_enable,
  // Oscillator outputs, asynchronous to ref_clk.
  input  wire logic              ext_fast_crystal,
  input  wire logic              int_fast_rc,
  input  wire logic              ext_slow_crystal,
  input  wire logic              int_slow_rc,
  // Clock control outputs.
  output scp_pkg::scp_mode_t     mode,
  output logic                   cpu_run,
  output logic                   core_clk_tick,
  output logic                   core_from_sub,
  output logic                   fast_osc_on,
  output logic                   sub_osc_on,
  output logic                   sub_clock_tick,
  output logic                   watchdog_clk_on,
  output logic                   low_voltage_detect_on,
  output logic                   fast_ready_flag
);

  // ==========================================================================
  // State
  typedef struct packed {
    scp_pkg::scp_mode_t mode;
    logic [2:0]         div_sel;
    logic               fwe;
    logic               ioh;
    logic               hls;
    logic               ick;
    logic               fast_rdy;
    logic [7:0]         rdy_cnt;
    logic [5:0]         div_cnt;
    logic [2:0]         sync_f;
    logic [2:0]         sync_s;
    logic               filt_f;
    logic               filt_s;
    logic [7:0]         rdata;
    logic               cpu_run;
    logic               core_on;
    logic               core_tick;
    logic               from_sub;
    logic               fast_on;
    logic               sub_on;
    logic               sub_tick;
    logic               wdt_on;
    logic               lvd_on;
  } scp_state_t;

  scp_state_t st_reg;
  scp_state_t st_next;

  logic       fast_raw;
  logic       slow_raw;
  logic       fast_tick;
  logic       slow_tick;
  logic       fast_sel;
  logic [5:0] div_mask;
  logic [7:0] mode_rd;

  // Fixed configuration picks the oscillator behind each clock.
  assign fast_raw = fast_src_is_rc ? int_fast_rc : ext_fast_crystal;
  assign slow_raw = sub_src_is_rc ? int_slow_rc : ext_slow_crystal;

  // Fast clock is wanted when the high bit is set or a divided code is set.
  assign fast_sel = st_reg.hls | (st_reg.div_sel >= scp_pkg::DIV_64);

  // Divider mask per select code; the sub codes never use the divider.
  always_comb
  begin
    div_mask = scp_pkg::MASK_1;
    if (st_reg.hls)
      div_mask = scp_pkg::MASK_1;
    else if (st_reg.div_sel == scp_pkg::DIV_64)
      div_mask = scp_pkg::MASK_64;
    else if (st_reg.div_sel == scp_pkg::DIV_32)
      div_mask = scp_pkg::MASK_32;
    else if (st_reg.div_sel == scp_pkg::DIV_16)
      div_mask = scp_pkg::MASK_16;
    else if (st_reg.div_sel == scp_pkg::DIV_8)
      div_mask = scp_pkg::MASK_8;
    else if (st_reg.div_sel == scp_pkg::DIV_4)
      div_mask = scp_pkg::MASK_4;
    else if (st_reg.div_sel == scp_pkg::DIV_2)
      div_mask = scp_pkg::MASK_2;
  end

  // Read image of the mode control register.
  always_comb
  begin
    mode_rd = 8'h00;
    mode_rd[scp_pkg::DIV_HI:scp_pkg::DIV_LO] = st_reg.div_sel;
    mode_rd[scp_pkg::BIT_FWE] = st_reg.fwe;
    mode_rd[scp_pkg::BIT_SUB_RDY] = st_reg.sub_on;
    mode_rd[scp_pkg::BIT_FAST_RDY] = st_reg.fast_rdy;
    mode_rd[scp_pkg::BIT_IOH] = st_reg.ioh;
    mode_rd[scp_pkg::BIT_HLS] = st_reg.hls;
  end

  // Oscillator edges count only while that oscillator is kept running.
  assign fast_tick = (st_reg.sync_f[1] == st_reg.sync_f[2]) &
                     st_reg.sync_f[2] & ~st_reg.filt_f & st_reg.fast_on;
  assign slow_tick = (st_reg.sync_s[1] == st_reg.sync_s[2]) &
                     st_reg.sync_s[2] & ~st_reg.filt_s & st_reg.sub_on;

  // ==========================================================================
  // Next state
  always_comb
  begin
    st_next = st_reg;

    // Three-stage synchronisers; a level counts once stages two and three
    // agree, which also filters a single-cycle glitch on the pin.
    st_next.sync_f = {st_reg.sync_f[1:0], fast_raw};
    st_next.sync_s = {st_reg.sync_s[1:0], slow_raw};
    if (st_reg.sync_f[1] == st_reg.sync_f[2])
      st_next.filt_f = st_reg.sync_f[2];
    if (st_reg.sync_s[1] == st_reg.sync_s[2])
      st_next.filt_s = st_reg.sync_s[2];

    // Register port; read data stand for one cycle only.
    st_next.rdata = 8'h00;
    if (reg_wr)
    begin
      if (reg_addr == scp_pkg::ADDR_MODE_CTRL)
      begin
        st_next.div_sel = reg_wdata[scp_pkg::DIV_HI:scp_pkg::DIV_LO];
        st_next.fwe = reg_wdata[scp_pkg::BIT_FWE];
        st_next.ioh = reg_wdata[scp_pkg::BIT_IOH];
        st_next.hls = reg_wdata[scp_pkg::BIT_HLS];
      end
      else if (reg_addr == scp_pkg::ADDR_IDLE_CTRL)
        st_next.ick = reg_wdata[scp_pkg::BIT_ICK];
    end
    if (reg_rd)
    begin
      if (reg_addr == scp_pkg::ADDR_MODE_CTRL)
        st_next.rdata = mode_rd;
      else if (reg_addr == scp_pkg::ADDR_IDLE_CTRL)
        st_next.rdata = {st_reg.ick, 7'h00};
    end

    // Mode sequencer; halt is taken only while the CPU runs.
    case (st_reg.mode)
      scp_pkg::M_NORMAL,
      scp_pkg::M_SLOW,
      scp_pkg::M_WAKE_SUB:
      begin
        if (halt_exec)
        begin
          if (!st_reg.ioh)
            st_next.mode = (wdt_enable && wdt_src_sub) ?
                           scp_pkg::M_SLEEP_SUB : scp_pkg::M_DEEP_SLEEP;
          else if (st_reg.ick)
            st_next.mode = scp_pkg::M_IDLE_ON;
          else
            st_next.mode = scp_pkg::M_IDLE_OFF;
        end
        else if (st_reg.mode == scp_pkg::M_WAKE_SUB)
        begin
          // Stay on the substitute clock until the crystal is ready.
          if (st_reg.fast_rdy || !fast_sel)
            st_next.mode = fast_sel ? scp_pkg::M_NORMAL : scp_pkg::M_SLOW;
        end
        else
          st_next.mode = fast_sel ? scp_pkg::M_NORMAL : scp_pkg::M_SLOW;
      end
      scp_pkg::M_IDLE_OFF,
      scp_pkg::M_SLEEP_SUB:
      begin
        // Fast wake needs a running sub clock and the crystal source.
        if (wake_event)
        begin
          if (fast_sel && st_reg.fwe && !fast_src_is_rc && !st_reg.fast_rdy)
            st_next.mode = scp_pkg::M_WAKE_SUB;
          else
            st_next.mode = fast_sel ? scp_pkg::M_NORMAL : scp_pkg::M_SLOW;
        end
      end
      scp_pkg::M_IDLE_ON,
      scp_pkg::M_DEEP_SLEEP:
      begin
        if (wake_event)
          st_next.mode = fast_sel ? scp_pkg::M_NORMAL : scp_pkg::M_SLOW;
      end
      default:
        st_next.mode = scp_pkg::M_NORMAL;
    endcase

    // Clock enables that follow the next mode.
    st_next.cpu_run = 1'b0;
    st_next.core_on = 1'b0;
    st_next.fast_on = 1'b0;
    st_next.sub_on = 1'b1;
    st_next.wdt_on = 1'b1;
    st_next.from_sub = !fast_sel;
    case (st_next.mode)
      scp_pkg::M_NORMAL:
      begin
        st_next.cpu_run = 1'b1;
        st_next.core_on = 1'b1;
        st_next.fast_on = 1'b1;
      end
      scp_pkg::M_SLOW:
      begin
        st_next.cpu_run = 1'b1;
        st_next.core_on = 1'b1;
        st_next.fast_on = 1'b0;
      end
      scp_pkg::M_WAKE_SUB:
      begin
        st_next.cpu_run = 1'b1;
        st_next.core_on = 1'b1;
        st_next.fast_on = 1'b1;
        st_next.from_sub = 1'b1;
      end
      scp_pkg::M_IDLE_ON:
      begin
        st_next.core_on = 1'b1;
        st_next.fast_on = fast_sel;
      end
      scp_pkg::M_IDLE_OFF:
        st_next.wdt_on = wdt_src_sub;
      scp_pkg::M_SLEEP_SUB:
        st_next.wdt_on = wdt_src_sub && wdt_enable;
      default:
      begin
        st_next.sub_on = 1'b0;
        st_next.wdt_on = 1'b0;
      end
    endcase

    // Voltage detect is held off in both sleep modes.
    st_next.lvd_on = voltage_detect_enable &&
                     (st_next.mode != scp_pkg::M_DEEP_SLEEP) &&
                     (st_next.mode != scp_pkg::M_SLEEP_SUB);

    // Fast ready: cleared with the oscillator, set after the crystal has
    // delivered its start-up ticks; the RC source is taken as ready at once.
    if (!st_reg.fast_on)
    begin
      st_next.fast_rdy = 1'b0;
      st_next.rdy_cnt = 8'h00;
    end
    else if (!st_reg.fast_rdy)
    begin
      if (fast_src_is_rc)
        st_next.fast_rdy = 1'b1;
      else if (fast_tick)
      begin
        st_next.rdy_cnt = st_reg.rdy_cnt + 8'h01;
        if (st_reg.rdy_cnt == scp_pkg::FAST_READY_LAST)
          st_next.fast_rdy = 1'b1;
      end
    end

    // Core tick from the sub clock or from the divided fast clock.  The
    // gate follows the next mode so that no tick leaks into a mode whose core clock is off.
    st_next.core_tick = 1'b0;
    if (fast_tick)
      st_next.div_cnt = st_reg.div_cnt + 6'h01;
    if (st_next.core_on)
    begin
      if (st_reg.from_sub)
        st_next.core_tick = slow_tick;
      else
        st_next.core_tick = fast_tick && st_reg.fast_rdy &&
                            ((st_reg.div_cnt & div_mask) == div_mask);
    end

    // Sub clock goes to the watchdog and timers whatever the core uses.
    st_next.sub_tick = slow_tick;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st_reg <= '0;
      st_reg.mode <= scp_pkg::M_SLOW;
      st_reg.div_sel <= scp_pkg::MODE_CTRL_RST[scp_pkg::DIV_HI:scp_pkg::DIV_LO];
      st_reg.fwe <= scp_pkg::MODE_CTRL_RST[scp_pkg::BIT_FWE];
      st_reg.ioh <= scp_pkg::MODE_CTRL_RST[scp_pkg::BIT_IOH];
      st_reg.hls <= scp_pkg::MODE_CTRL_RST[scp_pkg::BIT_HLS];
      st_reg.ick <= scp_pkg::ICK_RST;
      st_reg.sub_on <= 1'b1;
      st_reg.wdt_on <= 1'b1;
      st_reg.from_sub <= 1'b0;
    end
    else
      st_reg <= st_next;
  end

  // Outputs straight from the state register.
  assign reg_rdata = st_reg.rdata;
  assign mode = st_reg.mode;
  assign cpu_run = st_reg.cpu_run;
  assign core_clk_tick = st_reg.core_tick;
  assign core_from_sub = st_reg.from_sub;
  assign fast_osc_on = st_reg.fast_on;
  assign sub_osc_on = st_reg.sub_on;
  assign sub_clock_tick = st_reg.sub_tick;
  assign watchdog_clk_on = st_reg.wdt_on;
  assign low_voltage_detect_on = st_reg.lvd_on;
  assign fast_ready_flag = st_reg.fast_rdy;

  // ==========================================================================
  // Checks
  property p_slow_fast_off;
    @(posedge ref_clk) disable iff (srst)
    (st_reg.mode == scp_pkg::M_SLOW) && !$past(srst) |->
      !fast_osc_on && cpu_run;
  endproperty
  a_slow_fast_off: assert property (p_slow_fast_off)
    else $error("Fast oscillator runs in slow mode.");

  property p_deep_stops_sub;
    @(posedge ref_clk) disable iff (srst)
    (st_reg.mode == scp_pkg::M_DEEP_SLEEP) |->
      !sub_osc_on && !watchdog_clk_on && !core_clk_tick;
  endproperty
  a_deep_stops_sub: assert property (p_deep_stops_sub)
    else $error("Sub or watchdog clock alive in deep sleep.");

  property p_sleep_lvd_off;
    @(posedge ref_clk) disable iff (srst)
    (st_reg.mode inside {scp_pkg::M_DEEP_SLEEP, scp_pkg::M_SLEEP_SUB})
      |-> !low_voltage_detect_on;
  endproperty
  a_sleep_lvd_off: assert property (p_sleep_lvd_off)
    else $error("Voltage detect active during sleep.");

  property p_halt_sleep_kind;
    @(posedge ref_clk) disable iff (srst)
    (halt_exec && cpu_run && !st_reg.ioh) |=> (mode ==
      ((wdt_enable && wdt_src_sub) ? scp_pkg::M_SLEEP_SUB
                                   : scp_pkg::M_DEEP_SLEEP));
  endproperty
  a_halt_sleep_kind: assert property (p_halt_sleep_kind)
    else $error("Halt with idle bit low chose the wrong sleep.");

  property p_halt_idle_kind;
    @(posedge ref_clk) disable iff (srst)
    (halt_exec && cpu_run && st_reg.ioh) |=> !cpu_run && (mode ==
      ($past(st_reg.ick) ? scp_pkg::M_IDLE_ON : scp_pkg::M_IDLE_OFF));
  endproperty
  a_halt_idle_kind: assert property (p_halt_idle_kind)
    else $error("Halt with idle bit high chose the wrong idle.");

  property p_idle_off_wdt;
    @(posedge ref_clk) disable iff (srst)
    (st_reg.mode == scp_pkg::M_IDLE_OFF) |->
      (watchdog_clk_on == $past(wdt_src_sub)) && !fast_osc_on;
  endproperty
  a_idle_off_wdt: assert property (p_idle_off_wdt)
    else $error("Watchdog clock wrong in clock-off idle.");

  property p_idle_on_clocks;
    @(posedge ref_clk) disable iff (srst)
    (st_reg.mode == scp_pkg::M_IDLE_ON) |-> watchdog_clk_on && sub_osc_on;
  endproperty
  a_idle_on_clocks: assert property (p_idle_on_clocks)
    else $error("Clocks stopped in clock-on idle.");

  property p_ready_count;
    @(posedge ref_clk) disable iff (srst)
    $rose(fast_ready_flag) && !fast_src_is_rc |->
      (st_reg.rdy_cnt == scp_pkg::FAST_READY_TICKS);
  endproperty
  a_ready_count: assert property (p_ready_count)
    else $error("Fast ready set before 128 crystal ticks.");

  property p_wake_sub_core;
    @(posedge ref_clk) disable iff (srst)
    (st_reg.mode == scp_pkg::M_WAKE_SUB) |-> core_from_sub && fast_osc_on;
  endproperty
  a_wake_sub_core: assert property (p_wake_sub_core)
    else $error("Fast wake not running on the sub clock.");

  property p_undivided;
    @(posedge ref_clk) disable iff (srst)
    (st_reg.mode == scp_pkg::M_NORMAL) && st_reg.hls && !core_from_sub &&
      fast_tick && st_reg.fast_rdy && !halt_exec |=> core_clk_tick;
  endproperty
  a_undivided: assert property (p_undivided)
    else $error("Undivided fast clock missed a core tick.");

endmodule : scp_clock_power_ctrl

// *** rtl/scp_pkg.sv ***
// Constants, field layouts and mode type of the clock and power mode control.
package scp_pkg;

  // ==========================================================================
  // Register map
  localparam logic [3:0] ADDR_MODE_CTRL = 4'h0;
  localparam logic [3:0] ADDR_IDLE_CTRL = 4'h1;

  // Mode control register fields.
  localparam int DIV_HI = 7;
  localparam int DIV_LO = 5;
  localparam int BIT_FWE = 4;
  localparam int BIT_SUB_RDY = 3;
  localparam int BIT_FAST_RDY = 2;
  localparam int BIT_IOH = 1;
  localparam int BIT_HLS = 0;
  localparam logic [7:0] MODE_CTRL_RST = 8'hE2;

  // Idle control register field.
  localparam int BIT_ICK = 7;
  localparam logic ICK_RST = 1'b0;

  // ==========================================================================
  // Divider select codes
  localparam logic [2:0] DIV_SUB_A = 3'h0;
  localparam logic [2:0] DIV_SUB_B = 3'h1;
  localparam logic [2:0] DIV_64 = 3'h2;
  localparam logic [2:0] DIV_32 = 3'h3;
  localparam logic [2:0] DIV_16 = 3'h4;
  localparam logic [2:0] DIV_8 = 3'h5;
  localparam logic [2:0] DIV_4 = 3'h6;
  localparam logic [2:0] DIV_2 = 3'h7;

  // Divider masks: a core tick falls where the low counter bits are all one.
  localparam logic [5:0] MASK_1 = 6'h00;
  localparam logic [5:0] MASK_2 = 6'h01;
  localparam logic [5:0] MASK_4 = 6'h03;
  localparam logic [5:0] MASK_8 = 6'h07;
  localparam logic [5:0] MASK_16 = 6'h0F;
  localparam logic [5:0] MASK_32 = 6'h1F;
  localparam logic [5:0] MASK_64 = 6'h3F;

  // ==========================================================================
  // Timing
  localparam logic [7:0] FAST_READY_TICKS = 8'h80;
  localparam logic [7:0] FAST_READY_LAST = FAST_READY_TICKS - 8'h01;

  // ==========================================================================
  // Operating modes
  typedef enum logic [2:0] {
    M_NORMAL,
    M_SLOW,
    M_IDLE_OFF,
    M_IDLE_ON,
    M_DEEP_SLEEP,
    M_SLEEP_SUB,
    M_WAKE_SUB
  } scp_mode_t;

endpackage : scp_pkg

// *** tb/test_system_clock_power_mode_ctrl.sv ***
// Self-checking testbench of the clock and power mode controller.
`timescale 1ns/100ps

module test_system_clock_power_mode_ctrl;

  // ==========================================================================
  // Bench settings and signals
  localparam int LIMIT = 4000;
  localparam int RC_PER = 6;
  // Halt table rows: idle bit, keep bit, wdt enable, wdt from sub, then the
  // expected sub clock, watchdog clock and fast oscillator states.
  localparam logic [6:0] ROWS [6] = '{7'h1E, 7'h08, 7'h10, 7'h5E, 7'h54,
                                      7'h67};
  localparam scp_pkg::scp_mode_t HM [6] = '{scp_pkg::M_SLEEP_SUB,
    scp_pkg::M_DEEP_SLEEP, scp_pkg::M_DEEP_SLEEP, scp_pkg::M_IDLE_OFF,
    scp_pkg::M_IDLE_OFF, scp_pkg::M_IDLE_ON};

  // Design ports.
  logic               ref_clk;
  logic               srst;
  logic [3:0]         reg_addr;
  logic [7:0]         reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [7:0]         reg_rdata;
  logic               halt_exec;
  logic               wake_event;
  logic               fast_src_is_rc;
  logic               sub_src_is_rc;
  logic               wdt_src_sub;
  logic               wdt_enable;
  logic               voltage_detect_enable;
  logic               ext_fast_crystal;
  logic               int_fast_rc;
  logic               ext_slow_crystal;
  logic               int_slow_rc;
  scp_pkg::scp_mode_t mode;
  logic               cpu_run;
  logic               core_clk_tick;
  logic               core_from_sub;
  logic               fast_osc_on;
  logic               sub_osc_on;
  logic               sub_clock_tick;
  logic               watchdog_clk_on;
  logic               low_voltage_detect_on;
  logic               fast_ready_flag;
  // Bench state.
  int                 checks;
  int                 failures;
  logic               rd_pend = 1'b0;
  logic [7:0]         exp_q[$];

  scp_clock_power_ctrl i_scp_clock_power_ctrl (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .halt_exec(halt_exec), .wake_event(wake_event),
    .fast_src_is_rc(fast_src_is_rc), .sub_src_is_rc(sub_src_is_rc),
    .wdt_src_sub(wdt_src_sub), .wdt_enable(wdt_enable),
    .voltage_detect_enable(voltage_detect_enable),
    .ext_fast_crystal(ext_fast_crystal), .int_fast_rc(int_fast_rc),
    .ext_slow_crystal(ext_slow_crystal), .int_slow_rc(int_slow_rc),
    .mode(mode), .cpu_run(cpu_run), .core_clk_tick(core_clk_tick),
    .core_from_sub(core_from_sub), .fast_osc_on(fast_osc_on),
    .sub_osc_on(sub_osc_on), .sub_clock_tick(sub_clock_tick),
    .watchdog_clk_on(watchdog_clk_on),
    .low_voltage_detect_on(low_voltage_detect_on),
    .fast_ready_flag(fast_ready_flag)
  );

  // ==========================================================================
  // Clocks: oscillators toggle on falling ref_clk times, away from sampling.
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always #400 ext_fast_crystal = ~ext_fast_crystal;
  always #300 int_fast_rc = ~int_fast_rc;
  always #1000 ext_slow_crystal = ~ext_slow_crystal;
  always #1200 int_slow_rc = ~int_slow_rc;

  // ==========================================================================
  // Checking
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want)
    begin
      failures++;
      $display("wrong value at %0t ns: saw %h, want %h", $time, seen, want);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d, failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // Read data stand only in the cycle after the strobe, so look there.
  always @(posedge ref_clk)
  begin
    if (rd_pend && exp_q.size() > 0)
      check(16'(reg_rdata), 16'(exp_q.pop_front()));
    rd_pend <= reg_rd;
  end

  task automatic look(input scp_pkg::scp_mode_t m, input logic run,
                      input logic sub_on, input logic wd_on);
    check(16'(mode), 16'(m));
    check(16'(cpu_run), 16'(run));
    check(16'(sub_osc_on), 16'(sub_on));
    check(16'(watchdog_clk_on), 16'(wd_on));
  endtask : look

  // ==========================================================================
  // Drivers: each starts at a rising edge and holds its strobe one cycle.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] want);
    @(posedge ref_clk);
    exp_q.push_back(want);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : rd

  // One cycle of halt (h = 1) or of wake (h = 0).
  task automatic strobe(input logic h);
    @(posedge ref_clk);
    halt_exec <= h;
    wake_event <= !h;
    @(posedge ref_clk);
    halt_exec <= 1'b0;
    wake_event <= 1'b0;
  endtask : strobe

  task automatic settle();
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : settle

  // Counts cycles until a core tick (f = 0) or fast ready (f = 1) is seen.
  task automatic wait_sig(input logic f, output int n);
    n = 1;
    @(posedge ref_clk);
    while ((f ? fast_ready_flag : core_clk_tick) !== 1'b1)
    begin
      if (n >= LIMIT)
      begin
        failures++;
        report_and_stop();
      end
      @(posedge ref_clk);
      n++;
    end
  endtask : wait_sig

  task automatic spacing(output int n);
    wait_sig(1'b0, n);
    wait_sig(1'b0, n);
    wait_sig(1'b0, n);
  endtask : spacing

  task automatic do_reset();
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
  endtask : do_reset

  // ==========================================================================
  // Main sequence
  initial
  begin
    int         n;
    logic [3:0] a;
    logic [6:0] row;
    logic [7:0] w;
    void'($urandom(38));
    {reg_addr, reg_wdata, reg_wr, reg_rd, halt_exec, wake_event} = '0;
    {ext_fast_crystal, int_fast_rc, ext_slow_crystal, int_slow_rc} = '0;
    {fast_src_is_rc, sub_src_is_rc, wdt_src_sub, wdt_enable} = 4'h9;
    voltage_detect_enable = 1'b1;
    checks = 0;
    failures = 0;
    srst = 1'b1;
    @(negedge ref_clk);
    look(scp_pkg::M_SLOW, 1'b0, 1'b1, 1'b1);
    check(16'(fast_osc_on), 16'h0000);
    check(16'(fast_ready_flag), 16'h0000);
    @(posedge ref_clk);
    srst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rd(scp_pkg::ADDR_MODE_CTRL, scp_pkg::MODE_CTRL_RST | 8'h0C);
    rd(scp_pkg::ADDR_IDLE_CTRL, 8'h00);
    $display("test reset done");
    // Unmapped place and the unused idle control bits.
    a = 4'(2 + $urandom % 14);
    wr(a, 8'($urandom));
    rd(a, 8'h00);
    wr(scp_pkg::ADDR_IDLE_CTRL, 8'hFF);
    rd(scp_pkg::ADDR_IDLE_CTRL, 8'h80);
    $display("test refused access done");
    // Every divider code, high select first; read-only bits get noise.
    for (int c = 8; c >= 0; c--)
    begin
      w = (c == 8) ? 8'hE3 : {3'(c), 5'h02};
      wr(scp_pkg::ADDR_MODE_CTRL, w | 8'(($urandom % 4) << 2));
      spacing(n);
      check(16'(n), (c >= 2) ? 16'(RC_PER << (8 - c)) : 16'h0014);
      @(negedge ref_clk);
      check(16'(mode), (c >= 2) ? 16'(scp_pkg::M_NORMAL)
                                : 16'(scp_pkg::M_SLOW));
      check(16'(fast_osc_on), 16'(c >= 2));
      check(16'(core_from_sub), 16'(c < 2));
      rd(scp_pkg::ADDR_MODE_CTRL, w | ((c >= 2) ? 8'h0C : 8'h08));
    end
    $display("test divider done");
    // Halt into each low power mode, halt again, then wake.
    for (int i = 0; i < 6; i++)
    begin
      row = ROWS[i];
      @(posedge ref_clk);
      wdt_enable <= row[4];
      wdt_src_sub <= row[3];
      wr(scp_pkg::ADDR_MODE_CTRL, {6'h38, row[6], 1'b1});
      wr(scp_pkg::ADDR_IDLE_CTRL, {row[5], 7'h00});
      strobe(1'b1);
      settle();
      look(HM[i], 1'b0, row[2], row[1]);
      check(16'(fast_osc_on), 16'(row[0]));
      if (!row[6])
        check(16'(low_voltage_detect_on), 16'h0000);
      strobe(1'b1);
      settle();
      check(16'(mode), 16'(HM[i]));
      strobe(1'b0);
      settle();
      look(scp_pkg::M_NORMAL, 1'b1, 1'b1, 1'b1);
      check(16'(low_voltage_detect_on), 16'h0001);
    end
    $display("test halt modes done");
    // Crystal fast clock with fast wake from clock-off idle.
    fast_src_is_rc <= 1'b0;
    do_reset();
    wait_sig(1'b1, n);
    wr(scp_pkg::ADDR_MODE_CTRL, 8'hE3);
    spacing(n);
    check(16'(n), 16'h0008);
    @(posedge ref_clk);
    wdt_enable <= 1'b1;
    wdt_src_sub <= 1'b1;
    wr(scp_pkg::ADDR_MODE_CTRL, 8'hF3);
    wr(scp_pkg::ADDR_IDLE_CTRL, 8'h00);
    strobe(1'b1);
    repeat (4) settle();
    check(16'(fast_ready_flag), 16'h0000);
    strobe(1'b0);
    settle();
    look(scp_pkg::M_WAKE_SUB, 1'b1, 1'b1, 1'b1);
    check(16'(core_from_sub), 16'h0001);
    wait_sig(1'b1, n);
    check(16'(n >= 1000 && n <= 1050), 16'h0001);
    settle();
    look(scp_pkg::M_NORMAL, 1'b1, 1'b1, 1'b1);
    check(16'(core_from_sub), 16'h0000);
    rd(scp_pkg::ADDR_MODE_CTRL, 8'hFF);
    $display("test fast wake done");
    // Slow mode from the internal slow oscillator.
    sub_src_is_rc <= 1'b1;
    do_reset();
    wr(scp_pkg::ADDR_MODE_CTRL, 8'h02);
    spacing(n);
    check(16'(n), 16'h0018);
    @(negedge ref_clk);
    look(scp_pkg::M_SLOW, 1'b1, 1'b1, 1'b1);
    check(16'(fast_osc_on), 16'h0000);
    wait_sig(1'b0, n);
    check(16'(sub_clock_tick), 16'h0001);
    repeat (3) @(posedge ref_clk);
    $display("test slow source done");
    report_and_stop();
  end

endmodule : test_system_clock_power_mode_ctrl
